/* logic/dscd_code_conv.v */
// Converts a 12-bit contact code into a speed magnitude for the selected format
`timescale 1ns/1ps
`include "dscd_defs.vh"

module dscd_code_conv (
	input  wire        core_clk_in,
	input  wire        arst_n_in,
	input  wire [11:0] code_in,
	input  wire [1:0]  format_in,
	input  wire [14:0] max_speed_in,
	output reg  [14:0] speed_out,
	output reg         rev_code_out,
	output reg         bcd_err_out
);

	reg  [11:0] mag;
	reg  [11:0] full;
	reg         rev;
	reg         err;
	wire [3:0]  d0 = code_in[3:0];
	wire [3:0]  d1 = code_in[7:4];
	wire [3:0]  d2 = code_in[11:8];
	wire [3:0]  c0;
	wire [3:0]  c1;
	wire [3:0]  c2;
	wire [26:0] prod;
	wire [26:0] quot;

	// Out-of-range BCD digits are held at nine
	assign c0 = (d0 > `DSCD_BCD_MAX_DIGIT) ? `DSCD_BCD_MAX_DIGIT : d0;
	assign c1 = (d1 > `DSCD_BCD_MAX_DIGIT) ? `DSCD_BCD_MAX_DIGIT : d1;
	assign c2 = (d2 > `DSCD_BCD_MAX_DIGIT) ? `DSCD_BCD_MAX_DIGIT : d2;

	// Distance from zero code and full-scale divisor per format
	always @* begin
		mag  = 12'h000;
		full = `DSCD_FULL_UNSIGNED;
		rev  = 1'b0;
		err  = 1'b0;
		case (format_in)
			`DSCD_FMT_SIGNED: begin
				if (code_in[11]) begin
					mag  = code_in - `DSCD_CODE_ZERO_SGN;
					full = `DSCD_FULL_SGN_FWD;
				end else begin
					mag  = `DSCD_CODE_ZERO_SGN - code_in;
					full = `DSCD_FULL_SGN_REV;
					rev  = 1'b1;
				end
			end
			`DSCD_FMT_UNSIGNED: begin
				mag  = code_in;
				full = `DSCD_FULL_UNSIGNED;
			end
			`DSCD_FMT_BCD2: begin
				mag  = ({8'h00, c1} * 12'd10) + {8'h00, c0};
				full = `DSCD_FULL_BCD2;
				err  = (d0 > `DSCD_BCD_MAX_DIGIT) || (d1 > `DSCD_BCD_MAX_DIGIT);
			end
			default: begin
				mag  = ({8'h00, c2} * 12'd100) + ({8'h00, c1} * 12'd10)
					+ {8'h00, c0};
				full = `DSCD_FULL_BCD3;
				err  = (d0 > `DSCD_BCD_MAX_DIGIT) || (d1 > `DSCD_BCD_MAX_DIGIT)
					|| (d2 > `DSCD_BCD_MAX_DIGIT);
			end
		endcase
	end

	// Proportional speed: magnitude / full scale times maximum speed
	assign prod = {15'h0000, mag} * {12'h000, max_speed_in};
	assign quot = prod / {15'h0000, full};

	// Registered result
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			speed_out    <= 15'h0000;
			rev_code_out <= 1'b0;
			bcd_err_out  <= 1'b0;
		end else begin
			speed_out    <= quot[14:0];
			rev_code_out <= rev;
			bcd_err_out  <= err;
		end
	end

endmodule

/* logic/dscd_defs.vh */
// Constants for the digital speed command decoder: formats, scales, register map
`ifndef DSCD_DEFS_VH
`define DSCD_DEFS_VH

// Speed command formats selected by speed_input_format
`define DSCD_FMT_SIGNED     2'h0
`define DSCD_FMT_UNSIGNED   2'h1
`define DSCD_FMT_BCD2       2'h2
`define DSCD_FMT_BCD3       2'h3
`define DSCD_FMT_RST        2'h0

// Code points and full-scale divisors per format
`define DSCD_CODE_ZERO_SGN  12'h800
`define DSCD_FULL_UNSIGNED  12'hfff
`define DSCD_FULL_SGN_FWD   12'h7ff
`define DSCD_FULL_SGN_REV   12'h800
`define DSCD_FULL_BCD2      12'h063
`define DSCD_FULL_BCD3      12'h3e7
`define DSCD_BCD_MAX_DIGIT  4'h9

// Override scaling: factor = (OFS + MUL*v) / DEN, v is a 12-bit code for 0..+10 V
`define DSCD_OVR_OFS        16'h4ffb
`define DSCD_OVR_MUL        4'h7
`define DSCD_OVR_DEN        31'h00009ff6

// General-purpose input function-select codes
`define DSCD_FSEL_DIGITAL   5'h0f
`define DSCD_FSEL_OVERRIDE  5'h10
`define DSCD_FSEL_MAX       5'h15
`define DSCD_FSEL_RST       5'h00
`define DSCD_NUM_GPIN       12

// Register map (word index on the register port)
`define DSCD_REG_FORMAT     5'h00
`define DSCD_REG_MAXSPD     5'h01
`define DSCD_REG_STATUS     5'h02
`define DSCD_REG_SPEED      5'h03
`define DSCD_REG_CODE       5'h04
`define DSCD_REG_FSEL_BASE  5'h10
`define DSCD_MAXSPD_RST     15'h0000

// Status register fields
`define DSCD_ST_DIGITAL     0
`define DSCD_ST_OVR_VALID   1
`define DSCD_ST_TAP         2
`define DSCD_ST_DIR_REV     3
`define DSCD_ST_BCD_ERR     4
`define DSCD_ST_OVR_APPLIED 5
`define DSCD_ST_SRC_LO      6

// Speed source codes
`define DSCD_SRC_ANALOG     2'h0
`define DSCD_SRC_DIGITAL    2'h1
`define DSCD_SRC_PRESET     2'h2

`endif

/* logic/dscd_ovr_scale.v */
// Applies the 0.5..1.2 override factor to a speed and clamps it at maximum speed
`timescale 1ns/1ps
`include "dscd_defs.vh"

module dscd_ovr_scale (
	input  wire        core_clk_in,
	input  wire        arst_n_in,
	input  wire [14:0] speed_in,
	input  wire        apply_in,
	input  wire [11:0] override_voltage_input,
	input  wire [14:0] max_speed_in,
	output reg  [14:0] speed_out
);

	wire [15:0] factor;
	wire [30:0] prod;
	wire [30:0] quot;
	wire [14:0] limited;

	// Factor numerator: offset gives 0.5 at 0 V, slope reaches 1.2 at full code
	assign factor = `DSCD_OVR_OFS + ({4'h0, override_voltage_input} * {12'h000, `DSCD_OVR_MUL});
	assign prod   = {16'h0000, speed_in} * {15'h0000, factor};
	assign quot   = prod / `DSCD_OVR_DEN;
	assign limited = (quot > {16'h0000, max_speed_in}) ? max_speed_in : quot[14:0];

	// Registered speed; pass-through when the override is not applied
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			speed_out <= 15'h0000;
		end else if (apply_in) begin
			speed_out <= limited;
		end else begin
			speed_out <= speed_in;
		end
	end

endmodule

/* logic/dscd_top.v */
// Digital speed command decoder: contact code to spindle speed reference
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "dscd_defs.vh"

module dscd_top (
	input  wire        core_clk_in,
	input  wire        arst_n_in,
	// Register port
	input  wire [4:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [15:0] reg_rdata_out,
	// Speed command contacts, bit 0 is the first line
	input  wire [11:0] speed_contact_in,
	// General-purpose input contacts
	input  wire [11:0] gp_contact_in,
	// Other speed sources
	input  wire [14:0] analog_speed_in,
	input  wire        preset_active_in,
	input  wire [14:0] preset_speed_in,
	// Override voltage as a 12-bit code spanning 0 V to +10 V
	input  wire [11:0] override_voltage_input,
	// Start and tapping contacts
	input  wire        fwd_start_in,
	input  wire        rev_start_in,
	input  wire        tap_contact_in,
	// Results
	output wire [14:0] speed_ref_out,
	output reg         dir_reverse_out,
	output reg         digital_active_out,
	output reg         override_valid_out,
	output reg         tap_flag_out
);

	// Configuration registers
	reg  [1:0]  speed_input_format_q;
	reg  [14:0] max_speed_limit_q;
	reg  [4:0]  input_function_select_q [0:`DSCD_NUM_GPIN-1];

	// Decoded general-purpose functions
	wire [11:0] dig_hit;
	wire [11:0] ovr_hit;
	wire        dig_en_d;
	wire        ovr_en_d;

	// First pipeline stage
	reg         dig_en_q;
	reg         ovr_en_q;
	reg         preset_q;
	reg  [14:0] analog_q;
	reg  [14:0] preset_spd_q;
	reg  [11:0] code_q;
	reg         rev_start_q;
	reg         fwd_start_q;
	reg         fmt_signed_q;

	// Converter results
	wire [14:0] conv_speed;
	wire        conv_rev;
	wire        conv_bcd_err;

	// Source selection
	reg  [14:0] src_speed;
	reg  [1:0]  src_sel;
	wire        apply_ovr;
	wire        dir_d;

	// Second pipeline stage
	reg  [1:0]  src_q;
	reg         ovr_applied_q;
	reg         bcd_err_q;

	// Register access helpers
	wire        fsel_space;
	wire [3:0]  fsel_idx;
	wire [15:0] status_word;
	reg  [15:0] rd_mux;

	assign fsel_space = (reg_addr_in[4] == 1'b1) && (reg_addr_in[3:0] < 4'd12);
	assign fsel_idx   = reg_addr_in[3:0];

	// Format and maximum speed registers
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			speed_input_format_q <= `DSCD_FMT_RST;
			max_speed_limit_q    <= `DSCD_MAXSPD_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `DSCD_REG_FORMAT) begin
				speed_input_format_q <= reg_wdata_in[1:0];
			end
			if (reg_addr_in == `DSCD_REG_MAXSPD) begin
				max_speed_limit_q <= reg_wdata_in[14:0];
			end
		end
	end

	// Per-input function selectors and their decode
	genvar gi;
	generate
		for (gi = 0; gi < `DSCD_NUM_GPIN; gi = gi + 1) begin : g_fsel
			always @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					input_function_select_q[gi] <= `DSCD_FSEL_RST;
				end else if (reg_wr_in && fsel_space && (fsel_idx == gi)
					&& (reg_wdata_in[4:0] <= `DSCD_FSEL_MAX)) begin
					input_function_select_q[gi] <= reg_wdata_in[4:0];    // Out of range kept
				end
			end
			assign dig_hit[gi] = gp_contact_in[gi]
				&& (input_function_select_q[gi] == `DSCD_FSEL_DIGITAL);
			assign ovr_hit[gi] = gp_contact_in[gi]
				&& (input_function_select_q[gi] == `DSCD_FSEL_OVERRIDE);
		end
	endgenerate

	assign dig_en_d = |dig_hit;
	assign ovr_en_d = |ovr_hit;

	// First stage: capture contacts and sources alongside the converter
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dig_en_q     <= 1'b0;
			ovr_en_q     <= 1'b0;
			preset_q     <= 1'b0;
			analog_q     <= 15'h0000;
			preset_spd_q <= 15'h0000;
			code_q       <= 12'h000;
			rev_start_q  <= 1'b0;
			fwd_start_q  <= 1'b0;
			fmt_signed_q <= 1'b0;
		end else begin
			dig_en_q     <= dig_en_d;
			ovr_en_q     <= ovr_en_d;
			preset_q     <= preset_active_in;
			analog_q     <= analog_speed_in;
			preset_spd_q <= preset_speed_in;
			code_q       <= speed_contact_in;
			rev_start_q  <= rev_start_in;
			fwd_start_q  <= fwd_start_in;
			fmt_signed_q <= (speed_input_format_q == `DSCD_FMT_SIGNED);
		end
	end

	// Contact code to proportional speed in the selected format
	dscd_code_conv u_conv (
		.core_clk_in  (core_clk_in),
		.arst_n_in    (arst_n_in),
		.code_in      (speed_contact_in),
		.format_in    (speed_input_format_q),
		.max_speed_in (max_speed_limit_q),
		.speed_out    (conv_speed),
		.rev_code_out (conv_rev),
		.bcd_err_out  (conv_bcd_err)
	);

	// Speed source priority: digital contacts, then preset setting, then analog
	always @* begin
		if (dig_en_q) begin
			src_speed = conv_speed;
			src_sel   = `DSCD_SRC_DIGITAL;
		end else if (preset_q) begin
			src_speed = preset_spd_q;
			src_sel   = `DSCD_SRC_PRESET;
		end else begin
			src_speed = analog_q;
			src_sel   = `DSCD_SRC_ANALOG;
		end
	end

	// Override only for analog or digital sources
	assign apply_ovr = ovr_en_q && (src_sel != `DSCD_SRC_PRESET);

	// Direction: signed code direction, inverted when reverse-run start is closed without forward start
	assign dir_d = (dig_en_q && fmt_signed_q && conv_rev)
		^ (rev_start_q && !fwd_start_q);

	// Override scaling and clamp
	dscd_ovr_scale u_scale (
		.core_clk_in            (core_clk_in),
		.arst_n_in              (arst_n_in),
		.speed_in               (src_speed),
		.apply_in               (apply_ovr),
		.override_voltage_input (override_voltage_input),
		.max_speed_in           (max_speed_limit_q),
		.speed_out              (speed_ref_out)
	);

	// Second stage: flags aligned with the scaled speed, except the tap flag taken straight from its contact
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dir_reverse_out    <= 1'b0;
			digital_active_out <= 1'b0;
			override_valid_out <= 1'b0;
			tap_flag_out       <= 1'b0;
			src_q              <= `DSCD_SRC_ANALOG;
			ovr_applied_q      <= 1'b0;
			bcd_err_q          <= 1'b0;
		end else begin
			dir_reverse_out    <= dir_d;
			digital_active_out <= dig_en_q;
			override_valid_out <= ovr_en_q;
			tap_flag_out       <= tap_contact_in;
			src_q              <= src_sel;
			ovr_applied_q      <= apply_ovr;
			bcd_err_q          <= conv_bcd_err && dig_en_q;
		end
	end

	// Status word built from live flags
	assign status_word = {8'h00, src_q, ovr_applied_q, bcd_err_q, dir_reverse_out,
		tap_flag_out, override_valid_out, digital_active_out};

	// Read multiplexer; unmapped addresses read zero
	always @* begin
		rd_mux = 16'h0000;
		if (fsel_space) begin
			rd_mux = {11'h000, input_function_select_q[fsel_idx]};
		end else begin
			case (reg_addr_in)
				`DSCD_REG_FORMAT: rd_mux = {14'h0000, speed_input_format_q};
				`DSCD_REG_MAXSPD: rd_mux = {1'b0, max_speed_limit_q};
				`DSCD_REG_STATUS: rd_mux = status_word;
				`DSCD_REG_SPEED:  rd_mux = {1'b0, speed_ref_out};
				`DSCD_REG_CODE:   rd_mux = {4'h0, code_q};
				default:          rd_mux = 16'h0000;
			endcase
		end
	end

	// Read data valid only in the cycle after the read strobe
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rd_mux;
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

endmodule

/* tb/dscd_ctl_model.sv */
// Controller model driving the twelve speed command contacts
`timescale 1ns/1ps
module dscd_ctl_model (
	input  wire        core_clk_in,
	input  wire [11:0] code_in,
	output reg  [11:0] contact_out
);
	initial contact_out = 12'h000;
	// Closed contact is one, first line carries the least significant bit
	always @(posedge core_clk_in) begin
		contact_out <= code_in;
	end
endmodule

/* tb/dscd_sva.sv */
// Port checker for the digital speed command decoder
`timescale 1ns/1ps
module dscd_sva (
	input wire        core_clk_in,
	input wire        arst_n_in,
	input wire [4:0]  reg_addr_in,
	input wire        reg_rd_in,
	input wire [15:0] reg_rdata_out,
	input wire [11:0] gp_contact_in,
	input wire [14:0] analog_speed_in,
	input wire        preset_active_in,
	input wire [14:0] preset_speed_in,
	input wire        fwd_start_in,
	input wire        rev_start_in,
	input wire        tap_contact_in,
	input wire [14:0] speed_ref_out,
	input wire        dir_reverse_out,
	input wire        digital_active_out,
	input wire        override_valid_out,
	input wire        tap_flag_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	// Tapping flag follows its contact one cycle later
	property p_tap; tap_contact_in |=> tap_flag_out; endproperty
	a_tap: assert property (p_tap) else $error("tap flag not raised");
	property p_tap_off; !tap_contact_in |=> !tap_flag_out; endproperty
	a_tap_off: assert property (p_tap_off) else $error("tap flag stuck");
	// Open general inputs give neither digital command nor override
	property p_idle; gp_contact_in == 12'h000 |-> ##2 !override_valid_out && !digital_active_out;
	endproperty
	a_idle: assert property (p_idle) else $error("flags set with open inputs");
	// Preset speed passes without override
	property p_preset; preset_active_in && gp_contact_in == 12'h000
		|-> ##2 speed_ref_out == $past(preset_speed_in, 2); endproperty
	a_preset: assert property (p_preset) else $error("preset speed wrong");
	// Analog speed is used when nothing else is selected
	property p_analog; !preset_active_in && gp_contact_in == 12'h000
		|-> ##2 speed_ref_out == $past(analog_speed_in, 2); endproperty
	a_analog: assert property (p_analog) else $error("analog speed wrong");
	// Start contact picks the direction outside digital signed mode
	property p_dir; gp_contact_in == 12'h000 && fwd_start_in != rev_start_in
		|-> ##2 dir_reverse_out == $past(rev_start_in, 2); endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	// Speed register reads the live reference
	property p_rd_spd; reg_rd_in && reg_addr_in == 5'h03
		|=> reg_rdata_out == {1'b0, $past(speed_ref_out)}; endproperty
	a_rd_spd: assert property (p_rd_spd) else $error("speed read wrong");
	// Status register mirrors the tap and override flags
	property p_rd_st; reg_rd_in && reg_addr_in == 5'h02 |=> reg_rdata_out[2] ==
		$past(tap_flag_out) && reg_rdata_out[1] == $past(override_valid_out); endproperty
	a_rd_st: assert property (p_rd_st) else $error("status read wrong");
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the digital speed command decoder
`timescale 1ns/1ps
module tb_top;
	localparam MAXS = 10000;
	localparam [143:0] CODES = {12'h000, 12'h001, 12'h002, 12'h7ff, 12'h800, 12'h801,
		12'hffe, 12'hfff, 12'h099, 12'h999, 12'h998, 12'hf01};
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [4:0]  addr = 5'h00;
	reg  [15:0] wdata = 16'h0000;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg  [11:0] gp = 12'h000;
	reg  [14:0] ana = 15'h0000;
	reg         pre = 1'b0;
	reg  [14:0] pspd = 15'h0000;
	reg  [11:0] ovr = 12'h000;
	reg         fwd = 1'b1;
	reg         rev = 1'b0;
	reg         tap = 1'b0;
	reg  [11:0] code = 12'h000;
	reg  [15:0] d;
	wire [11:0] cont;
	wire [15:0] rdata;
	wire [14:0] spd;
	wire        dir;
	wire        dig;
	wire        ovv;
	wire        tapf;
	integer     error_cnt = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	integer     f;
	integer     i;

	dscd_top i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.speed_contact_in(cont), .gp_contact_in(gp), .analog_speed_in(ana),
		.preset_active_in(pre), .preset_speed_in(pspd), .override_voltage_input(ovr),
		.fwd_start_in(fwd), .rev_start_in(rev), .tap_contact_in(tap), .speed_ref_out(spd),
		.dir_reverse_out(dir), .digital_active_out(dig), .override_valid_out(ovv),
		.tap_flag_out(tapf));
	dscd_ctl_model i_ctl (.core_clk_in(clk), .code_in(code), .contact_out(cont));

	initial forever #12.5 clk = ~clk;

	// BCD digit above nine counts as nine
	function integer dg(input [3:0] x);
		dg = (x > 4'h9) ? 9 : x;
	endfunction
	// Expected speed for a format and code at maximum speed MAXS
	function [15:0] exp_spd(input [1:0] fm, input [11:0] c);
		integer m;
		case (fm)
			2'h1: m = c * MAXS / 4095;
			2'h2: m = (dg(c[7:4]) * 10 + dg(c[3:0])) * MAXS / 99;
			2'h3: m = (dg(c[11:8]) * 100 + dg(c[7:4]) * 10 + dg(c[3:0])) * MAXS / 999;
			default: m = (c >= 12'h800) ? (c - 2048) * MAXS / 2047 : (2048 - c) * MAXS / 2048;
		endcase
		exp_spd = m[15:0];
	endfunction
	// Expected overridden speed, clamped at maximum
	function [15:0] ovr_exp(input [15:0] n);
		integer t;
		t = n * (20475 + 7 * ovr) / 40950;
		ovr_exp = (t > MAXS) ? MAXS : t[15:0];
	endfunction

	task chk(input [15:0] got, input [15:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input [4:0] a, input [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input [4:0] a, output [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task apply(input [11:0] c);
		@(posedge clk);
		code <= c;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	task t_regs;
		rd_reg(5'h00, d);
		chk(d, 16'h0000);
		rd_reg(5'h10, d);
		chk(d, 16'h0000);
		wr_reg(5'h01, 16'h2710);
		wr_reg(5'h10, 16'h000f);
		wr_reg(5'h11, 16'h0010);
		wr_reg(5'h12, 16'h0016);
		rd_reg(5'h12, d);
		chk(d, 16'h0000);
		wr_reg(5'h12, 16'h0015);
		rd_reg(5'h12, d);
		chk(d, 16'h0015);
		rd_reg(5'h1c, d);
		chk(d, 16'h0000);
		rd_reg(5'h01, d);
		chk(d, 16'h2710);
	endtask
	task t_fmt;
		@(posedge clk);
		gp <= 12'h001;
		for (f = 0; f < 4; f = f + 1) begin
			wr_reg(5'h00, f[15:0]);
			for (i = 0; i < 12; i = i + 1) begin
				apply(CODES[(11 - i) * 12 +: 12]);
				chk({1'b0, spd}, exp_spd(f[1:0], code));
				chk({14'h0, dig, dir}, {14'h0, 1'b1, f == 0 && code < 12'h800});
			end
		end
		// Last code has a bad hundreds digit: digital source with digit error flagged
		rd_reg(5'h02, d);
		chk(d, 16'h0051);
	endtask
	task t_rev;
		wr_reg(5'h00, 16'h0000);
		@(posedge clk);
		fwd <= 1'b0;
		rev <= 1'b1;
		apply(12'h001);
		chk({15'h0, dir}, 16'h0000);
		apply(12'hfff);
		chk({15'h0, dir}, 16'h0001);
		rd_reg(5'h04, d);
		chk(d, 16'h0fff);
		// Analog source: reverse-run start alone sets the direction
		@(posedge clk);
		gp <= 12'h000;
		apply(12'h001);
		chk({15'h0, dir}, 16'h0001);
		@(posedge clk);
		fwd <= 1'b1;
		rev <= 1'b0;
	endtask
	task t_ovr;
		wr_reg(5'h00, 16'h0001);
		@(posedge clk);
		gp <= 12'h003;
		apply(12'h800);
		chk({1'b0, spd}, ovr_exp(exp_spd(2'h1, 12'h800)));
		chk({15'h0, ovv}, 16'h0001);
		@(posedge clk);
		ovr <= 12'hfff;
		apply(12'h800);
		chk({1'b0, spd}, ovr_exp(exp_spd(2'h1, 12'h800)));
		apply(12'hfff);
		chk({1'b0, spd}, 16'h2710);
		rd_reg(5'h03, d);
		chk(d, 16'h2710);
		@(posedge clk);
		gp <= 12'h002;
		ana <= 15'h1388;
		apply(12'h000);
		chk({1'b0, spd}, ovr_exp(16'h1388));
		rd_reg(5'h02, d);
		chk(d, 16'h0022);
		@(posedge clk);
		pre <= 1'b1;
		pspd <= 15'h1b58;
		apply(12'h000);
		chk({1'b0, spd}, 16'h1b58);
		rd_reg(5'h02, d);
		chk(d, 16'h0082);
		// Preset alone, then analog alone, both without override
		@(posedge clk);
		gp <= 12'h000;
		apply(12'h000);
		chk({1'b0, spd}, 16'h1b58);
		chk({15'h0, ovv}, 16'h0000);
		@(posedge clk);
		pre <= 1'b0;
		apply(12'h000);
		chk({1'b0, spd}, 16'h1388);
	endtask
	task t_tap;
		@(posedge clk);
		tap <= 1'b1;
		apply(12'h000);
		chk({15'h0, tapf}, 16'h0001);
		rd_reg(5'h02, d);
		chk(d & 16'h0004, 16'h0004);
		@(posedge clk);
		tap <= 1'b0;
		apply(12'h000);
		chk({15'h0, tapf}, 16'h0000);
	endtask

	// Mid-run reset brings the registers back to their reset values
	task t_rst;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(5'h00, d);
		chk(d, 16'h0000);
		rd_reg(5'h10, d);
		chk(d, 16'h0000);
	endtask

	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Cuts a hung run short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			end_sim;
		end
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_fmt;
		t_rev;
		t_ovr;
		t_tap;
		t_rst;
		end_sim;
	end
endmodule

bind dscd_top dscd_sva i_sva (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.gp_contact_in(gp_contact_in), .analog_speed_in(analog_speed_in),
	.preset_active_in(preset_active_in), .preset_speed_in(preset_speed_in),
	.fwd_start_in(fwd_start_in), .rev_start_in(rev_start_in),
	.tap_contact_in(tap_contact_in), .speed_ref_out(speed_ref_out),
	.dir_reverse_out(dir_reverse_out), .digital_active_out(digital_active_out),
	.override_valid_out(override_valid_out), .tap_flag_out(tap_flag_out));
